// *** rtl/gic_top.sv ***
// gate interval capture counter with apb registers and dma fifo
//
// How it works
// - pulse mode measures high and low time
// - count selected source edges between gate edges
// - single pulse is two consecutive width captures
// - implicit pulse mode pushes every gate edge
// - after arm, wait for selected starting edge
// - setting selects first phase, high or low
// - sample clock pushes last complete pulse pair
// - hardware-timed single point equals sample-clocked mode
// - no pulse between sample clocks flags overrun
// - pulse pairs, semi-period singles, same hardware
// - no sample clock timing for semi-period
// - semi-period measures every consecutive gate interval
// - single semi-period acts like single width capture
// - implicit semi-period pushes every edge, first selectable
// - period mode counts one full gate period
// - source is 100M, 20M, 100k or routed
// - single capture stores, then ignores further edges
// - armed mid-phase waits for next active transition
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module gic_top #(
   parameter int unsigned FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // measured signals
   input wire logic gate_in,
   input wire logic sample_clk_in,
   input wire logic routed_src_in,
   // dma stream
   output logic dma_valid_out,
   output gic_pkg::gic_sample_t dma_data_out,
   input wire logic dma_ready_in,
   // interrupt
   output logic irq_out
);
   import gic_pkg::*;

   localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == ADDR_CTRL) || (a == ADDR_CFG) || (a == ADDR_STAT) ||
                   (a == ADDR_INT_STAT) || (a == ADDR_INT_EN) ||
                   (a == ADDR_INT_CLR) || (a == ADDR_LAST);
   endfunction

   gic_cfg_t cfg_q;
   gic_state_t state_q;
   logic [INT_W-1:0] int_stat_q, int_en_q, int_set, int_clr;
   logic [DIV_W-1:0] div_cnt_q, div_limit;
   logic pready_q, apb_wr, arm_req, disarm_req;
   logic gate_prev_q, sclk_prev_q, src_prev_q;
   logic src_tick, gate_rise, gate_fall, gate_any, start_now, sclk_edge;
   logic [31:0] cnt_q, first_hold_q, pair_hi_q, pair_lo_q, pend_lo_q, last_q;
   logic cur_high_q, half_q, got_first_q, pair_ready_q, pend_q, seen_sclk_q;
   logic is_sampled, is_period, edge_evt, end_first, pair_now, pair_avail;
   logic sclk_evt, restart, finish, overrun_evt, ovf_evt;
   logic [31:0] now_hi, now_lo, take_hi, take_lo;
   logic push;
   gic_sample_t push_data;
   gic_sample_t mem_q [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
   logic [PTR_W:0] fill_q;
   logic full, empty, pop, push_ok;

   // ----------------------------------------------------------------
   // apb slave: one wait state so read data comes from a flop
   // ----------------------------------------------------------------
   assign apb_wr = psel_in & penable_in & pready_q & pwrite_in;
   assign arm_req = apb_wr & (paddr_in == ADDR_CTRL) & pwdata_in[CTRL_ARM_BIT];
   assign disarm_req = apb_wr & (paddr_in == ADDR_CTRL) & pwdata_in[CTRL_DISARM_BIT];
   assign int_clr = (apb_wr && paddr_in == ADDR_INT_CLR) ? pwdata_in[INT_W-1:0] : INT_RESET;
   assign pready_out = pready_q;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pready_q <= 1'b0;
         prdata_out <= WORD_ZERO;
         pslverr_out <= 1'b0;
      end else if (psel_in && penable_in && !pready_q) begin
         pready_q <= 1'b1;
         pslverr_out <= !addr_known(paddr_in);
         prdata_out <= WORD_ZERO;
         if (!pwrite_in) begin
            case (paddr_in)
               ADDR_CFG: prdata_out <= {24'h00_0000, cfg_q};
               ADDR_STAT: prdata_out <= {16'h0000, 8'(fill_q), 3'b000, pend_q,
                                         pair_ready_q, half_q, state_q};
               ADDR_INT_STAT: prdata_out <= {29'h0000_0000, int_stat_q};
               ADDR_INT_EN: prdata_out <= {29'h0000_0000, int_en_q};
               ADDR_LAST: prdata_out <= last_q;
               default: prdata_out <= WORD_ZERO;
            endcase
         end
      end else begin
         pready_q <= 1'b0;
         pslverr_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg_q <= gic_cfg_t'(CFG_RESET);
         int_en_q <= INT_RESET;
      end else if (apb_wr && paddr_in == ADDR_CFG) begin
         cfg_q <= gic_cfg_t'(pwdata_in[CFG_W-1:0]);
      end else if (apb_wr && paddr_in == ADDR_INT_EN) begin
         int_en_q <= pwdata_in[INT_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // source timebase: the 20M and 100k rates come from one divider
   // ----------------------------------------------------------------
   assign div_limit = (cfg_q.src == GIC_SRC_20M) ? DIV_MID_M1 : DIV_SLOW_M1;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         div_cnt_q <= DIV_RESET;
      end else if (div_cnt_q >= div_limit) begin
         div_cnt_q <= DIV_RESET;
      end else begin
         div_cnt_q <= div_cnt_q + 10'h001;
      end
   end

   always_comb begin
      case (cfg_q.src)
         GIC_SRC_100M: src_tick = 1'b1;
         GIC_SRC_20M, GIC_SRC_100K: src_tick = (div_cnt_q == div_limit);
         GIC_SRC_ROUTED: src_tick = cfg_q.src_falling ? (src_prev_q & ~routed_src_in)
                                                     : (~src_prev_q & routed_src_in);
         default: src_tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // edge detection on gate, sample clock and routed source
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gate_prev_q <= 1'b0;
         sclk_prev_q <= 1'b0;
         src_prev_q <= 1'b0;
      end else begin
         gate_prev_q <= gate_in;
         sclk_prev_q <= sample_clk_in;
         src_prev_q <= routed_src_in;
      end
   end

   assign gate_rise = gate_in & ~gate_prev_q;
   assign gate_fall = ~gate_in & gate_prev_q;
   assign gate_any = gate_rise | gate_fall;
   assign start_now = cfg_q.first_phase_select ? gate_fall : gate_rise;
   assign sclk_edge = cfg_q.sclk_falling ? (sclk_prev_q & ~sample_clk_in)
                                        : (~sclk_prev_q & sample_clk_in);

   // ----------------------------------------------------------------
   // measurement events
   // ----------------------------------------------------------------
   // semi-period has no sampled encoding, so a sample clock never acts on it
   assign is_sampled = (cfg_q.mode == GIC_MODE_PULSE_SAMPLED) ||
                       (cfg_q.mode == GIC_MODE_PULSE_HW_TIMED_SINGLE_POINT);
   assign is_period = (cfg_q.mode == GIC_MODE_PERIOD_SINGLE);
   assign edge_evt = (state_q == GIC_ST_COUNT) & gate_any;
   assign end_first = cur_high_q != cfg_q.first_phase_select;
   assign pair_now = edge_evt & is_sampled & ~end_first & got_first_q;
   assign now_hi = cfg_q.first_phase_select ? cnt_q : first_hold_q;
   assign now_lo = cfg_q.first_phase_select ? first_hold_q : cnt_q;
   assign pair_avail = pair_ready_q | pair_now;
   assign take_hi = pair_now ? now_hi : pair_hi_q;
   assign take_lo = pair_now ? now_lo : pair_lo_q;
   assign sclk_evt = is_sampled & sclk_edge &
                     ((state_q == GIC_ST_WAIT) || (state_q == GIC_ST_COUNT));
   assign overrun_evt = sclk_evt & ~pair_avail & seen_sclk_q;
   // period mode keeps counting through the opposite edge
   assign restart = ((state_q == GIC_ST_WAIT) & start_now) |
                    (edge_evt & ~is_period);
   assign finish = edge_evt & ((cfg_q.mode == GIC_MODE_SEMI_SINGLE) |
                   ((cfg_q.mode == GIC_MODE_PULSE_SINGLE) & half_q) |
                   (is_period & start_now));

   always_comb begin
      push = 1'b0;
      push_data = '0;
      if (pend_q) begin
         push = 1'b1;
         push_data = '{phase_high: 1'b0, ticks: pend_lo_q};
      end else if (sclk_evt && pair_avail) begin
         push = 1'b1;
         push_data = '{phase_high: 1'b1, ticks: take_hi};
      end else if (edge_evt && !is_sampled && (!is_period || start_now)) begin
         push = 1'b1;
         push_data = '{phase_high: cur_high_q, ticks: cnt_q};
      end
   end

   // ----------------------------------------------------------------
   // arm / capture state
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= GIC_ST_IDLE;
      end else if (disarm_req) begin
         state_q <= GIC_ST_IDLE;
      end else if (arm_req) begin
         state_q <= (cfg_q.mode == GIC_MODE_NONE) ? GIC_ST_IDLE : GIC_ST_WAIT;
      end else begin
         case (state_q)
            GIC_ST_WAIT: if (start_now) begin
               state_q <= GIC_ST_COUNT;
            end
            GIC_ST_COUNT: if (finish) begin
               state_q <= GIC_ST_DONE;
            end
            GIC_ST_IDLE, GIC_ST_DONE: state_q <= state_q;
            default: state_q <= GIC_ST_IDLE;
         endcase
      end
   end

   // a source edge in the gate edge cycle belongs to the new interval
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_q <= WORD_ZERO;
         cur_high_q <= 1'b0;
      end else if (restart) begin
         cnt_q <= {31'h0000_0000, src_tick};
         cur_high_q <= gate_in;
      end else if (state_q == GIC_ST_COUNT && src_tick) begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         half_q <= 1'b0;
      end else if (arm_req) begin
         half_q <= 1'b0;
      end else if (edge_evt) begin
         half_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // sample-clocked pulse pairing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         first_hold_q <= WORD_ZERO;
         got_first_q <= 1'b0;
         pair_hi_q <= WORD_ZERO;
         pair_lo_q <= WORD_ZERO;
      end else if (arm_req) begin
         got_first_q <= 1'b0;
      end else if (edge_evt && is_sampled) begin
         if (end_first) begin
            first_hold_q <= cnt_q;
            got_first_q <= 1'b1;
         end else begin
            got_first_q <= 1'b0;
         end
         if (pair_now) begin
            pair_hi_q <= now_hi;
            pair_lo_q <= now_lo;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pair_ready_q <= 1'b0;
         seen_sclk_q <= 1'b0;
      end else if (arm_req) begin
         pair_ready_q <= 1'b0;
         seen_sclk_q <= 1'b0;
      end else if (sclk_evt) begin
         pair_ready_q <= 1'b0;
         seen_sclk_q <= 1'b1;
      end else if (pair_now) begin
         pair_ready_q <= 1'b1;
      end
   end

   // the low half of a pair goes out one cycle after the high half
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_q <= 1'b0;
         pend_lo_q <= WORD_ZERO;
      end else begin
         pend_q <= ~pend_q & sclk_evt & pair_avail;
         pend_lo_q <= take_lo;
      end
   end

   // ----------------------------------------------------------------
   // capture fifo drained by dma
   // ----------------------------------------------------------------
   // a push into a full fifo is dropped and flagged, never stalls capture
   assign full = (fill_q == (PTR_W + 1)'(FIFO_DEPTH));
   assign empty = (fill_q == '0);
   assign pop = dma_ready_in & ~empty;
   assign push_ok = push & ~full;
   assign ovf_evt = push & full;
   assign dma_valid_out = ~empty;
   assign dma_data_out = mem_q[rd_ptr_q];

   always_ff @(posedge clk_sys_in) begin
      if (push_ok) begin
         mem_q[wr_ptr_q] <= push_data;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q <= '0;
         last_q <= WORD_ZERO;
      end else begin
         if (push_ok) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            last_q <= push_data.ticks;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push_ok && !pop) begin
            fill_q <= fill_q + 1'b1;
         end else if (pop && !push_ok) begin
            fill_q <= fill_q - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupts: set wins over a clear in the same cycle
   // ----------------------------------------------------------------
   always_comb begin
      int_set = INT_RESET;
      int_set[INT_DONE_BIT] = finish & (state_q == GIC_ST_COUNT);
      int_set[INT_OVERRUN_BIT] = overrun_evt;
      int_set[INT_FIFO_OVF_BIT] = ovf_evt;
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         int_stat_q <= INT_RESET;
      end else begin
         int_stat_q <= (int_stat_q & ~int_clr) | int_set;
      end
   end

   assign irq_out = |(int_stat_q & int_en_q);

endmodule

`default_nettype wire

// *** rtl/gic_pkg.sv ***
// constants, types and register map of the gate interval capture block
package gic_pkg;

   // ----------------------------------------------------------------
   // clock and timebases
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TB_FAST_HZ = 100_000_000;
   localparam int unsigned TB_MID_HZ = 20_000_000;
   localparam int unsigned TB_SLOW_HZ = 100_000;
   localparam int unsigned DIV_W = 10;
   localparam logic [DIV_W-1:0] DIV_MID_M1 = DIV_W'(CLK_HZ / TB_MID_HZ - 1);
   localparam logic [DIV_W-1:0] DIV_SLOW_M1 = DIV_W'(CLK_HZ / TB_SLOW_HZ - 1);
   localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
   localparam logic [7:0] ADDR_INT_EN = 8'h10;
   localparam logic [7:0] ADDR_INT_CLR = 8'h14;
   localparam logic [7:0] ADDR_LAST = 8'h18;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_ARM_BIT = 0;
   localparam int unsigned CTRL_DISARM_BIT = 1;
   localparam int unsigned CFG_W = 8;
   localparam int unsigned INT_W = 3;
   localparam int unsigned INT_DONE_BIT = 0;
   localparam int unsigned INT_OVERRUN_BIT = 1;
   localparam int unsigned INT_FIFO_OVF_BIT = 2;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h07;
   localparam logic [INT_W-1:0] INT_RESET = 3'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      GIC_MODE_PULSE_SINGLE = 3'b000,
      GIC_MODE_PULSE_IMPLICIT = 3'b001,
      GIC_MODE_PULSE_SAMPLED = 3'b010,
      GIC_MODE_PULSE_HW_TIMED_SINGLE_POINT = 3'b011,
      GIC_MODE_SEMI_SINGLE = 3'b100,
      GIC_MODE_SEMI_IMPLICIT = 3'b101,
      GIC_MODE_PERIOD_SINGLE = 3'b110,
      GIC_MODE_NONE = 3'b111
   } gic_mode_t;

   typedef enum logic [1:0] {
      GIC_SRC_100M = 2'b00,
      GIC_SRC_20M = 2'b01,
      GIC_SRC_100K = 2'b10,
      GIC_SRC_ROUTED = 2'b11
   } gic_src_t;

   typedef enum logic [1:0] {
      GIC_ST_IDLE = 2'b00,
      GIC_ST_WAIT = 2'b01,
      GIC_ST_COUNT = 2'b10,
      GIC_ST_DONE = 2'b11
   } gic_state_t;

   // layout of the configuration register, bit 7 down to bit 0
   typedef struct packed {
      logic sclk_falling;
      logic src_falling;
      gic_src_t src;
      logic first_phase_select;
      gic_mode_t mode;
   } gic_cfg_t;

   typedef struct packed {
      logic phase_high;
      logic [31:0] ticks;
   } gic_sample_t;

endpackage

// *** tb/gic_monitor.sv ***
// port checker of the gate interval capture block
`timescale 1ns/1ns
`default_nettype none
module gic_monitor
   import gic_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // measured, dma and interrupt
   input wire logic gate_in,
   input wire logic sample_clk_in,
   input wire logic dma_valid_out,
   input wire gic_sample_t dma_data_out,
   input wire logic dma_ready_in,
   input wire logic irq_out
);
   // ----------
   // shadow registers
   // ----------
   logic [2:0] mode_q, en_q, act_q;
   logic gate_q, sclk_q;
   wire logic wr_ok = psel_in && penable_in && pready_out && pwrite_in;
   // a push follows its edge within four cycles
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode_q <= GIC_MODE_NONE;
         en_q <= INT_RESET;
         act_q <= 3'h0;
         gate_q <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         gate_q <= gate_in;
         sclk_q <= sample_clk_in;
         if (wr_ok && paddr_in == ADDR_CFG) mode_q <= pwdata_in[2:0];
         if (wr_ok && paddr_in == ADDR_INT_EN) en_q <= pwdata_in[INT_W-1:0];
         if (gate_in != gate_q || sample_clk_in != sclk_q) act_q <= 3'h4;
         else if (act_q != 3'h0) act_q <= act_q - 3'h1;
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   ready_one_cycle_a: assert property (pready_out |=> !pready_out)
      else $error("pready held");
   ready_one_wait_a: assert property (psel_in && penable_in && !$past(penable_in)
      |-> !pready_out ##1 pready_out) else $error("pready timing");
   ready_needs_req_a: assert property (pready_out |-> psel_in && penable_in)
      else $error("stray pready");
   error_reads_zero_a: assert property (pslverr_out |-> pready_out && prdata_out == WORD_ZERO)
      else $error("bad slave error");
   unmapped_error_a: assert property (pready_out |->
      pslverr_out == (paddr_in > ADDR_LAST || paddr_in[1:0] != 2'b00))
      else $error("slave error vs map");
   head_held_a: assert property (dma_valid_out && !dma_ready_in
      |=> dma_valid_out && $stable(dma_data_out)) else $error("head changed");
   push_cause_a: assert property ($rose(dma_valid_out) |-> act_q != 3'h0)
      else $error("push without edge");
   idle_mode_a: assert property (mode_q == GIC_MODE_NONE && !dma_valid_out |=> !dma_valid_out)
      else $error("push in no mode");
   irq_masked_a: assert property (en_q == INT_RESET |-> !irq_out)
      else $error("irq while masked");
   dma_move_c: cover property (dma_valid_out && dma_ready_in);
   irq_rise_c: cover property ($rose(irq_out));
   slave_error_c: cover property (pslverr_out);
endmodule
bind gic_top gic_monitor u_mon (
   .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .gate_in(gate_in), .sample_clk_in(sample_clk_in),
   .dma_valid_out(dma_valid_out), .dma_data_out(dma_data_out),
   .dma_ready_in(dma_ready_in), .irq_out(irq_out)
);
`default_nettype wire

// *** tb/gic_gate_model.sv ***
// model of gate, sample clock and routed timebase
`timescale 1ns/1ns
`default_nettype none
module gic_gate_model (
   // clock
   input wire logic clk_sys_in,
   // driven signals
   output logic gate_out,
   output logic sample_clk_out,
   output logic routed_src_out
);
   initial begin
      gate_out = 1'b0;
      sample_clk_out = 1'b0;
      routed_src_out = 1'b0;
   end
   // free-running timebase, rising every two cycles
   always @(posedge clk_sys_in) begin
      routed_src_out <= ~routed_src_out;
   end
   // call just after a rising edge; holds n cycles
   task automatic phase(input logic v, input int n);
      gate_out <= v;
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic sample_edge();
      sample_clk_out <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      sample_clk_out <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
   endtask
endmodule
`default_nettype wire

// *** tb/tb_gate_interval_counter_capture.sv ***
// self-checking bench of the gate interval capture block
`timescale 1ns/1ns
`default_nettype none
module tb_gate_interval_counter_capture;
   import gic_pkg::*;
   typedef struct packed {
      logic chk_phase;
      gic_sample_t s;
   } gic_exp_t;
   logic clk_sys_in, sys_rst_in;
   logic psel, penable, pwrite, pready, pslverr, dma_valid, dma_ready, irq;
   logic gate, sclk, rsrc;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   gic_sample_t dma_data;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [31:0] rng = 32'h0000_1439, rs = 32'h0000_1439;
   gic_exp_t exp_q[$];
   gic_top #(.FIFO_DEPTH(16)) u_dut (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .gate_in(gate), .sample_clk_in(sclk),
      .routed_src_in(rsrc), .dma_valid_out(dma_valid), .dma_data_out(dma_data),
      .dma_ready_in(dma_ready), .irq_out(irq)
   );
   gic_gate_model gm (
      .clk_sys_in(clk_sys_in), .gate_out(gate), .sample_clk_out(sclk),
      .routed_src_out(rsrc)
   );
   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   task automatic cmp(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // trailing idle cycle: no two psel writes at one edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys_in);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      if (k >= 50) n_mismatch++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic burst(input logic [7:0] c, input logic pre);
      gic_cfg_t cfg;
      gic_exp_t x;
      logic [31:0] r;
      logic e, f, v;
      int dv, len, nexp, acc;
      cfg = c;
      case (cfg.src)
         GIC_SRC_20M: dv = int'(CLK_HZ / TB_MID_HZ);
         GIC_SRC_100K: dv = int'(CLK_HZ / TB_SLOW_HZ);
         GIC_SRC_ROUTED: dv = 2;
         default: dv = 1;
      endcase
      case (cfg.mode)
         GIC_MODE_PULSE_SINGLE: nexp = 2;
         GIC_MODE_PULSE_IMPLICIT, GIC_MODE_SEMI_IMPLICIT: nexp = 5;
         default: nexp = 1;
      endcase
      f = ~cfg.first_phase_select;
      acc = 0;
      wr(ADDR_INT_CLR, 32'h0000_0007);
      wr(ADDR_CFG, {24'h00_0000, c});
      gm.phase(pre ? f : ~f, 4);
      wr(ADDR_CTRL, 32'h0000_0001);
      if (pre) begin
         gm.phase(f, 6);
         gm.phase(~f, 5);
      end
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         len = dv * (2 + int'(rng % 6));
         v = f ^ i[0];
         acc = (i < 2) ? acc + len : acc;
         x.chk_phase = cfg.mode != GIC_MODE_PERIOD_SINGLE;
         x.s.phase_high = v;
         x.s.ticks = 32'((x.chk_phase ? len : acc) / dv);
         if (x.chk_phase ? i < nexp : i == 1) exp_q.push_back(x);
         gm.phase(v, len);
      end
      repeat (30) @(posedge clk_sys_in);
      cmp(32'(exp_q.size()), WORD_ZERO);
      if (nexp < 5) begin
         apb(1'b0, ADDR_INT_STAT, WORD_ZERO, r, e);
         cmp(32'(r[INT_DONE_BIT]), 32'h0000_0001);
         cmp(32'(irq), 32'h0000_0001);
         wr(ADDR_INT_CLR, 32'h0000_0001);
         cmp(32'(irq), WORD_ZERO);
      end
      wr(ADDR_CTRL, 32'h0000_0002);
   endtask
   task automatic sampled(input gic_mode_t m);
      gic_exp_t x;
      logic [31:0] r;
      logic e;
      int h, l;
      wr(ADDR_INT_CLR, 32'h0000_0007);
      wr(ADDR_CFG, {29'h0000_0000, m});
      gm.phase(1'b0, 4);
      wr(ADDR_CTRL, 32'h0000_0001);
      for (int j = 0; j < 2; j++) begin
         rng = xs(rng);
         h = 3 + int'(rng % 20);
         l = 3 + int'(rng[15:0] % 20);
         x.chk_phase = 1'b1;
         x.s = {1'b1, 32'(h + 12 * j)};
         exp_q.push_back(x);
         x.s = {1'b0, 32'(l)};
         exp_q.push_back(x);
         gm.phase(1'b1, h);
         gm.phase(1'b0, l);
         fork
            gm.phase(1'b1, 12);
            begin
               repeat (3) @(posedge clk_sys_in);
               gm.sample_edge();
            end
         join
      end
      apb(1'b0, ADDR_INT_STAT, WORD_ZERO, r, e);
      cmp(32'(r[INT_OVERRUN_BIT]), WORD_ZERO);
      gm.sample_edge();
      repeat (10) @(posedge clk_sys_in);
      apb(1'b0, ADDR_INT_STAT, WORD_ZERO, r, e);
      cmp(32'(r[INT_OVERRUN_BIT]), 32'h0000_0001);
      cmp(32'(exp_q.size()), WORD_ZERO);
      wr(ADDR_CTRL, 32'h0000_0002);
   endtask
   // ----------
   // dma sink, clock, watchdog, sequence
   // ----------
   always @(posedge clk_sys_in) begin
      gic_exp_t x;
      if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp(32'(dma_valid), WORD_ZERO);
         end else begin
            x = exp_q.pop_front();
            cmp(dma_data.ticks, x.s.ticks);
            if (x.chk_phase) begin
               cmp(32'(dma_data.phase_high), 32'(x.s.phase_high));
            end
         end
      end
      rs = xs(rs);
      dma_ready <= rs[1:0] != 2'b00;
   end
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      repeat (90000) @(posedge clk_sys_in);
      n_mismatch++;
      conclude();
   end
   initial begin
      logic [31:0] r;
      logic e;
      logic [8:0] tbl [11];
      tbl = '{9'h001, 9'h109, 9'h011, 9'h021, 9'h031, 9'h071, 9'h105, 9'h00D,
              9'h000, 9'h00C, 9'h106};
      sys_rst_in = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = WORD_ZERO;
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_sys_in);
      apb(1'b0, ADDR_CFG, WORD_ZERO, r, e);
      cmp(r, {24'h00_0000, CFG_RESET});
      apb(1'b0, ADDR_INT_EN, WORD_ZERO, r, e);
      cmp(r, WORD_ZERO);
      apb(1'b0, 8'h1C, WORD_ZERO, r, e);
      cmp(32'(e), 32'h0000_0001);
      wr(ADDR_INT_EN, 32'h0000_0003);
      for (int i = 0; i < 11; i++) burst(tbl[i][7:0], tbl[i][8]);
      sampled(GIC_MODE_PULSE_SAMPLED);
      sampled(GIC_MODE_PULSE_HW_TIMED_SINGLE_POINT);
      conclude();
   end
endmodule
`default_nettype wire
